/* include/synth_cfg_pkg.sv */
// constants for the synthesizer output, bleed and lock configuration registers
// Summary of operation
// - word with select code 0110 loads the output and bleed configuration register
// - word with select code 0111 loads the lock-detect and load-sync register
// - power-down bit 1 powers down, 0 restores; register contents are kept
// - power-down holds counters, stops oscillator, three-states pump, clears lock, disables outputs
// - serial input registers keep loading and latching during power-down
// - pump three-state bit 1 forces pump high impedance, 0 restores pumping
// - counter-reset bit 1 holds reference, feedback dividers and band select in reset
// - polarity bit 1 selects positive, 0 negative detector polarity
// - charge pump current comes from a four-bit field
// - gated bleed keeps bleed off until digital lock detect asserts
// - negative-bleed bit 1 enables constant negative bleed, 0 disables it
// - second-output select 1 gives undivided oscillator, 0 duplicates first output
// - feedback select 1 takes oscillator directly, 0 the output divider chain
// - divider select waits for main-register write when double buffering, else immediate
// - eight-bit field sets the bleed current level
// - mute-until-lock keeps output stage supply off until lock detected
// - first output enabled by its bit at 1, power from two-bit field
// - second output enabled when its bit is 0, power from two-bit field
// - load-sync aligns load-enable to reference edge chosen by edge-select bit
// - two-bit count of in-window cycles before lock; mode bit forces fixed window
// - with double buffering the divider value is held until a main-register write
package synth_cfg_pkg;
  localparam int WORD_W = 32;
  localparam logic [3:0] SEL_MAIN = 4'h0;
  localparam logic [3:0] SEL_CTRL = 4'h4;
  localparam logic [3:0] SEL_FIXED = 4'h5;
  localparam logic [3:0] SEL_OUT = 4'h6;
  localparam logic [3:0] SEL_LOCK = 4'h7;
  localparam logic [31:0] FIXED_WORD = 32'h0080_0025;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // control register fields
  localparam int CTRL_DBUF = 14;
  localparam int CTRL_CP_LSB = 10;
  localparam int CTRL_MUXLVL = 8;
  localparam int CTRL_POL = 7;
  localparam int CTRL_PD = 6;
  localparam int CTRL_TRI = 5;
  localparam int CTRL_CRST = 4;
  // output and bleed register fields
  localparam int OUT_BLPOL = 31;
  localparam int OUT_GATED = 30;
  localparam int OUT_NEGBL = 29;
  localparam int OUT_FUND = 25;
  localparam int OUT_FBSEL = 24;
  localparam int OUT_DIV_LSB = 21;
  localparam int OUT_BL_LSB = 13;
  localparam int OUT_MUTE = 11;
  localparam int OUT_BDIS = 9;
  localparam int OUT_BPWR_LSB = 7;
  localparam int OUT_AEN = 6;
  localparam int OUT_APWR_LSB = 4;
  // lock-detect and load-sync register fields
  localparam int LK_EDGE = 27;
  localparam int LK_SYNC = 25;
  localparam int LK_CNT_LSB = 8;
  localparam int LK_LOL = 7;
  localparam int LK_PREC_LSB = 5;
  localparam int LK_MODE = 4;
  localparam int LOCK_CNT_W = 14;
endpackage

/* verilog/serial_word_shifter.sv */
// three-wire serial word shifter with load-enable capture
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter
  import synth_cfg_pkg::*;
#(
  parameter int W = WORD_W
) (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // synchronous reset
  input wire logic i_sclk, // serial clock
  input wire logic i_sdata, // serial data, msb first
  input wire logic i_le, // load enable strobe
  output logic [W-1:0] o_word, // captured word
  output logic o_load // one-cycle pulse on load enable rise
);
  logic sclk_q;
  logic le_q;
  logic [W-1:0] shreg;
  wire sclk_rise = i_sclk & ~sclk_q;
  wire le_rise = i_le & ~le_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
      shreg <= '0;
      o_word <= '0;
      o_load <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
      le_q <= i_le;
      if (sclk_rise && !i_le) begin
        shreg <= {shreg[W-2:0], i_sdata};
      end
      o_load <= le_rise;
      if (le_rise) begin
        o_word <= shreg;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/load_ref_sync.sv */
// aligns a word transfer to a chosen reference edge when load-sync is on
`timescale 1ns/1ps
`default_nettype none
module load_ref_sync
  import synth_cfg_pkg::*;
#(
  parameter int W = WORD_W
) (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // synchronous reset
  input wire logic i_load, // transfer request pulse
  input wire logic [W-1:0] i_word, // word to transfer
  input wire logic i_sync_en, // load-sync enable
  input wire logic i_edge_rise, // 1 rising, 0 falling reference edge
  input wire logic i_ref, // sampled reference level
  output logic o_load, // transfer pulse
  output logic [W-1:0] o_word // transferred word
);
  logic ref_q;
  logic pending;
  logic [W-1:0] held;
  wire ref_edge = i_edge_rise ? (i_ref & ~ref_q) : (~i_ref & ref_q);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_q <= 1'b0;
      pending <= 1'b0;
      held <= '0;
      o_load <= 1'b0;
      o_word <= '0;
    end else begin
      ref_q <= i_ref;
      o_load <= 1'b0;
      if (i_load && !i_sync_en) begin
        o_load <= 1'b1;
        o_word <= i_word;
      end else if (i_load) begin
        pending <= 1'b1;
        held <= i_word;
      end else if (pending && ref_edge) begin
        pending <= 1'b0;
        o_load <= 1'b1;
        o_word <= held;
      end
    end
  end

  property p_sync_wait;
    @(posedge i_clk) disable iff (i_srst)
      (i_sync_en && (i_load || (pending && !ref_edge))) |=> !o_load;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("synced load issued off edge");

  property p_sync_edge;
    @(posedge i_clk) disable iff (i_srst)
      (pending && !i_load && (i_edge_rise ? $rose(i_ref) : $fell(i_ref)))
        |=> (o_load && (o_word == $past(held)));
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("synced load missed its edge");
endmodule
`default_nettype wire

/* verilog/synth_output_lock_config_regs.sv */
// control, output, bleed and lock-detect register bank of the synthesizer
`timescale 1ns/1ps
`default_nettype none
module synth_output_lock_config_regs
  import synth_cfg_pkg::*;
#(
  parameter int LOCK_CNT0 = 1024,
  parameter int LOCK_CNT1 = 2048,
  parameter int LOCK_CNT2 = 4096,
  parameter int LOCK_CNT3 = 8192
) (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_srst, // synchronous reset, active high
  input wire logic i_sclk, // serial clock
  input wire logic i_sdata, // serial data
  input wire logic i_load_enable_strobe, // load enable
  input wire logic i_reference_input, // sampled reference clock
  input wire logic i_phase_in_window, // phase error inside window this cycle
  output logic [3:0] o_pump_current_code, // charge pump current
  output logic o_mux_level_select, // diagnostic pin logic level
  output logic o_detector_polarity_bit, // 1 positive polarity
  output logic o_power_down_bit, // software power-down active
  output logic o_divider_hold, // counters held in load or reset state
  output logic o_band_select_reset, // oscillator band select reset
  output logic o_vco_enable, // oscillator running
  output logic o_pump_tristate, // charge pump high impedance
  output logic o_bleed_polarity, // bleed current polarity
  output logic o_bleed_enable, // negative bleed current flowing
  output logic [7:0] o_bleed_level_field, // bleed current level
  output logic o_second_out_fundamental_sel, // second output takes oscillator
  output logic o_feedback_source_sel, // 1 direct feedback
  output logic [2:0] o_out_divider_sel, // active output divider code
  output logic o_first_rf_enable, // first output stage on
  output logic [1:0] o_first_out_power, // first output power
  output logic o_second_rf_enable, // second output stage on
  output logic [1:0] o_second_out_power, // second output power
  output logic o_lock_detect, // digital lock detect
  output logic [1:0] o_lock_window_precision, // fractional window code
  output logic o_lock_window_fixed, // fixed narrow window
  output logic o_reference_loss_mode // loss of lock mode
);
  logic [WORD_W-1:0] sh_word;
  logic sh_load;
  logic [WORD_W-1:0] word;
  logic load;
  logic [WORD_W-1:0] ctrl_reg;
  logic [WORD_W-1:0] fixed_reg;
  logic [WORD_W-1:0] out_reg;
  logic [WORD_W-1:0] lock_reg;
  logic [2:0] div_active;
  logic ref_q;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic locked;

  serial_word_shifter u_shift (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_le(i_load_enable_strobe),
    .o_word(sh_word),
    .o_load(sh_load)
  );

  load_ref_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_load(sh_load),
    .i_word(sh_word),
    .i_sync_en(lock_reg[LK_SYNC]),
    .i_edge_rise(lock_reg[LK_EDGE]),
    .i_ref(i_reference_input),
    .o_load(load),
    .o_word(word)
  );

  // threshold for the consecutive in-window count
  function automatic logic [LOCK_CNT_W-1:0] lock_target(input logic [1:0] code);
    unique case (code)
      2'h0: lock_target = LOCK_CNT_W'(LOCK_CNT0);
      2'h1: lock_target = LOCK_CNT_W'(LOCK_CNT1);
      2'h2: lock_target = LOCK_CNT_W'(LOCK_CNT2);
      2'h3: lock_target = LOCK_CNT_W'(LOCK_CNT3);
    endcase
  endfunction

  // write decode
  wire [3:0] sel = word[3:0];
  wire wr_main = load && (sel == SEL_MAIN);
  wire wr_ctrl = load && (sel == SEL_CTRL);
  wire wr_fixed = load && (sel == SEL_FIXED);
  wire wr_out = load && (sel == SEL_OUT);
  wire wr_lock = load && (sel == SEL_LOCK);

  // control bits
  wire pd = ctrl_reg[CTRL_PD];
  wire cnt_rst = ctrl_reg[CTRL_CRST];
  wire dbuf = ctrl_reg[CTRL_DBUF];
  wire ref_rise = i_reference_input & ~ref_q;
  wire in_window = i_phase_in_window;
  wire lock_clear = pd | cnt_rst;
  wire [LOCK_CNT_W-1:0] target = lock_target(lock_reg[LK_CNT_LSB +: 2]);

  // divider select: immediate or held for main write
  wire div_now = wr_out && !dbuf;
  wire div_buffered = wr_main && dbuf;
  wire [2:0] next_div_active = div_now ? word[OUT_DIV_LSB +: 3] :
    (div_buffered ? out_reg[OUT_DIV_LSB +: 3] : div_active);

  // output stage gating
  wire mute_ok = !out_reg[OUT_MUTE] || locked;
  wire next_first_rf_enable = out_reg[OUT_AEN] && !pd && mute_ok;
  wire next_second_rf_enable = !out_reg[OUT_BDIS] && !pd && mute_ok;
  wire gate_ok = !out_reg[OUT_GATED] || locked;
  wire next_bleed_enable = out_reg[OUT_NEGBL] && !pd && gate_ok;
  wire next_pump_tristate = pd || ctrl_reg[CTRL_TRI];
  wire next_divider_hold = pd || cnt_rst;

  // register file; keeps loading during power-down
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_reg <= REG_RESET;
      fixed_reg <= REG_RESET;
      out_reg <= REG_RESET;
      lock_reg <= REG_RESET;
      div_active <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= word;
      end
      if (wr_fixed) begin
        fixed_reg <= word;
      end
      if (wr_out) begin
        out_reg <= word;
      end
      if (wr_lock) begin
        lock_reg <= word;
      end
      div_active <= next_div_active;
    end
  end

  // lock detector counts consecutive in-window reference cycles
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_q <= 1'b0;
      lock_cnt <= '0;
      locked <= 1'b0;
    end else begin
      ref_q <= i_reference_input;
      if (lock_clear) begin
        lock_cnt <= '0;
        locked <= 1'b0;
      end else if (ref_rise && !in_window) begin
        lock_cnt <= '0;
        locked <= 1'b0;
      end else if (ref_rise && !locked) begin
        lock_cnt <= lock_cnt + 1'b1;
        locked <= (lock_cnt + 1'b1) >= target;
      end
    end
  end

  // registered outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pump_current_code <= 4'h0;
      o_mux_level_select <= 1'b0;
      o_detector_polarity_bit <= 1'b0;
      o_power_down_bit <= 1'b0;
      o_divider_hold <= 1'b0;
      o_band_select_reset <= 1'b0;
      o_vco_enable <= 1'b0;
      o_pump_tristate <= 1'b1;
      o_bleed_polarity <= 1'b0;
      o_bleed_enable <= 1'b0;
      o_bleed_level_field <= 8'h00;
      o_second_out_fundamental_sel <= 1'b0;
      o_feedback_source_sel <= 1'b0;
      o_out_divider_sel <= 3'h0;
      o_first_rf_enable <= 1'b0;
      o_first_out_power <= 2'h0;
      o_second_rf_enable <= 1'b0;
      o_second_out_power <= 2'h0;
      o_lock_detect <= 1'b0;
      o_lock_window_precision <= 2'h0;
      o_lock_window_fixed <= 1'b0;
      o_reference_loss_mode <= 1'b0;
    end else begin
      o_pump_current_code <= ctrl_reg[CTRL_CP_LSB +: 4];
      o_mux_level_select <= ctrl_reg[CTRL_MUXLVL];
      o_detector_polarity_bit <= ctrl_reg[CTRL_POL];
      o_power_down_bit <= pd;
      o_divider_hold <= next_divider_hold;
      o_band_select_reset <= cnt_rst;
      o_vco_enable <= !pd;
      o_pump_tristate <= next_pump_tristate;
      o_bleed_polarity <= out_reg[OUT_BLPOL];
      o_bleed_enable <= next_bleed_enable;
      o_bleed_level_field <= out_reg[OUT_BL_LSB +: 8];
      o_second_out_fundamental_sel <= out_reg[OUT_FUND];
      o_feedback_source_sel <= out_reg[OUT_FBSEL];
      o_out_divider_sel <= div_active;
      o_first_rf_enable <= next_first_rf_enable;
      o_first_out_power <= out_reg[OUT_APWR_LSB +: 2];
      o_second_rf_enable <= next_second_rf_enable;
      o_second_out_power <= out_reg[OUT_BPWR_LSB +: 2];
      o_lock_detect <= locked && !lock_clear;
      o_lock_window_precision <= lock_reg[LK_PREC_LSB +: 2];
      o_lock_window_fixed <= lock_reg[LK_MODE];
      o_reference_loss_mode <= lock_reg[LK_LOL];
    end
  end

  property p_route_out;
    @(posedge i_clk) disable iff (i_srst)
      wr_out |=> (out_reg == $past(word));
  endproperty
  a_route_out: assert property (p_route_out) else $error("output word not stored");

  property p_route_lock;
    @(posedge i_clk) disable iff (i_srst)
      wr_lock |=> (lock_reg == $past(word)) ##1 (o_lock_window_fixed == $past(word[LK_MODE], 2));
  endproperty
  a_route_lock: assert property (p_route_lock) else $error("lock word not routed");

  property p_pd_effects;
    @(posedge i_clk) disable iff (i_srst)
      pd |=> (!o_vco_enable && o_pump_tristate && o_divider_hold && !o_lock_detect
        && !o_first_rf_enable && !o_second_rf_enable && !o_bleed_enable);
  endproperty
  a_pd_effects: assert property (p_pd_effects) else $error("power-down effect missing");

  property p_pd_loads;
    @(posedge i_clk) disable iff (i_srst)
      (pd && wr_out) |=> (out_reg == $past(word));
  endproperty
  a_pd_loads: assert property (p_pd_loads) else $error("load ignored in power-down");

  property p_tristate;
    @(posedge i_clk) disable iff (i_srst)
      ctrl_reg[CTRL_TRI] |=> o_pump_tristate;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pump not three-stated");

  property p_counter_reset;
    @(posedge i_clk) disable iff (i_srst)
      cnt_rst |=> (o_band_select_reset && o_divider_hold && !locked);
  endproperty
  a_counter_reset: assert property (p_counter_reset) else $error("counters not held");

  property p_polarity;
    @(posedge i_clk) disable iff (i_srst)
      $changed(ctrl_reg[CTRL_POL]) |=> (o_detector_polarity_bit == $past(ctrl_reg[CTRL_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_dbuf_hold;
    @(posedge i_clk) disable iff (i_srst)
      (dbuf && !wr_main) |=> $stable(div_active);
  endproperty
  a_dbuf_hold: assert property (p_dbuf_hold) else $error("divider changed without main write");

  property p_dbuf_apply;
    @(posedge i_clk) disable iff (i_srst)
      (dbuf && wr_main) |=> (div_active == $past(out_reg[OUT_DIV_LSB +: 3]));
  endproperty
  a_dbuf_apply: assert property (p_dbuf_apply) else $error("divider not loaded by main write");

  property p_mute;
    @(posedge i_clk) disable iff (i_srst)
      (out_reg[OUT_MUTE] && !locked) |=> (!o_first_rf_enable && !o_second_rf_enable);
  endproperty
  a_mute: assert property (p_mute) else $error("output on before lock");

  property p_gated_bleed;
    @(posedge i_clk) disable iff (i_srst)
      (out_reg[OUT_GATED] && !locked) |=> !o_bleed_enable;
  endproperty
  a_gated_bleed: assert property (p_gated_bleed) else $error("bleed on before lock");

  property p_second_enable;
    @(posedge i_clk) disable iff (i_srst)
      (out_reg[OUT_BDIS]) |=> !o_second_rf_enable;
  endproperty
  a_second_enable: assert property (p_second_enable) else $error("second output not disabled");

  property p_fixed_store;
    @(posedge i_clk) disable iff (i_srst)
      wr_fixed |=> (fixed_reg == $past(word));
  endproperty
  a_fixed_store: assert property (p_fixed_store) else $error("reserved word not stored");
endmodule
`default_nettype wire

/* testbench/serial_host_model.sv */
// host model driving the three-wire programming port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic i_clk, // system clock
  output logic o_sclk, // serial clock, idle low
  output logic o_sdata, // serial data
  output logic o_le // load enable
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_le = 1'b0;
  end
  // msb first, select code last; each clock level held two cycles, each data bit four
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge i_clk) begin
        o_sclk <= 1'b0;
        o_sdata <= w[i];
      end
      @(posedge i_clk);
      @(posedge i_clk) o_sclk <= 1'b1;
      @(posedge i_clk);
    end
    // released data line shows the inverse of the last bit
    @(posedge i_clk) begin
      o_sclk <= 1'b0;
      o_sdata <= ~w[0];
    end
    @(posedge i_clk) o_le <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk) o_le <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the synthesizer configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import synth_cfg_pkg::*;
  logic i_clk, i_srst, ref_in, in_win;
  logic [1:0] ref_cnt;
  wire logic sclk, sdata, le;
  wire logic mux_lv, pol, pd, hold, band, vco, tri_st, bl_pol, bl_en, fund, fbsel;
  wire logic a_en, b_en, lkd, w_fix, reference_loss_mode;
  wire logic [3:0] pump;
  wire logic [7:0] bl_lvl;
  wire logic [2:0] div_o;
  wire logic [1:0] a_pwr, b_pwr, prec;
  wire logic [36:0] seen = {pump, mux_lv, pol, pd, hold, band, vco, tri_st, bl_pol, bl_en,
    bl_lvl, fund, fbsel, div_o, a_en, a_pwr, b_en, b_pwr, lkd, prec, w_fix, reference_loss_mode};
  logic [31:0] ctrl, outr, lockr;
  logic [2:0] div;
  logic lk;
  integer seed;
  int miscompares, checks_done, ref_rises;

  serial_host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_le(le));

  synth_output_lock_config_regs #(.LOCK_CNT0(2), .LOCK_CNT1(3), .LOCK_CNT2(4), .LOCK_CNT3(5))
  DUT (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_sdata(sdata),
    .i_load_enable_strobe(le), .i_reference_input(ref_in), .i_phase_in_window(in_win),
    .o_pump_current_code(pump), .o_mux_level_select(mux_lv), .o_detector_polarity_bit(pol),
    .o_power_down_bit(pd), .o_divider_hold(hold), .o_band_select_reset(band),
    .o_vco_enable(vco), .o_pump_tristate(tri_st), .o_bleed_polarity(bl_pol),
    .o_bleed_enable(bl_en), .o_bleed_level_field(bl_lvl), .o_second_out_fundamental_sel(fund),
    .o_feedback_source_sel(fbsel), .o_out_divider_sel(div_o), .o_first_rf_enable(a_en),
    .o_first_out_power(a_pwr), .o_second_rf_enable(b_en), .o_second_out_power(b_pwr),
    .o_lock_detect(lkd), .o_lock_window_precision(prec), .o_lock_window_fixed(w_fix),
    .o_reference_loss_mode(reference_loss_mode));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // reference clock, eight system cycles a period
  always @(posedge i_clk) begin
    ref_cnt <= ref_cnt + 2'd1;
    if (ref_cnt == 2'd3) begin
      ref_in <= ~ref_in;
      if (!ref_in) ref_rises <= ref_rises + 1;
    end
  end

  function automatic logic [36:0] expect_vec();
    logic p;
    logic gate;
    p = ctrl[6];
    gate = !outr[11] | lk;
    return {ctrl[13:10], ctrl[8], ctrl[7], p, p | ctrl[4], ctrl[4], !p, p | ctrl[5], outr[31],
      outr[29] & !p & (!outr[30] | lk), outr[20:13], outr[25], outr[24], div,
      outr[6] & !p & gate, outr[5:4], !outr[9] & !p & gate, outr[8:7],
      lk & !p & !ctrl[4], lockr[6:5], lockr[4], lockr[7]};
  endfunction

  function automatic logic [31:0] word_for(input logic [3:0] c, input logic [31:0] r);
    case (c)
      SEL_OUT: return (r & 32'he3ff_ebf0) | 32'h1400_0006;
      SEL_LOCK: return (r & 32'h0a00_03f0) | 32'h0400_0007;
      SEL_FIXED: return FIXED_WORD;
      SEL_CTRL: return (r & 32'h3fff_fff0) | 32'h0000_0004;
      default: return {r[31:4], c};
    endcase
  endfunction

  task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one word through the port, model update, compare once settled
  task automatic put(input logic [31:0] w);
    host.send(w);
    case (w[3:0])
      SEL_CTRL: begin
        ctrl = w;
        if (w[6] | w[4]) lk = 1'b0;
      end
      SEL_OUT: begin
        outr = w;
        if (!ctrl[14]) div = w[23:21];
      end
      SEL_LOCK: lockr = w;
      SEL_MAIN: if (ctrl[14]) div = outr[23:21];
      default: ;
    endcase
    repeat (20) @(posedge i_clk);
    #1 check(seen, expect_vec());
  endtask

  task automatic rises(input int n);
    int r0;
    r0 = ref_rises;
    while (ref_rises < r0 + n) @(posedge i_clk);
    repeat (6) @(posedge i_clk);
  endtask

  initial begin
    i_srst = 1'b1;
    in_win = 1'b0;
    ref_in = 1'b0;
    ref_cnt = 2'd0;
    seed = 32'h718c;
    ctrl = 32'h0000_0000;
    outr = 32'h0000_0000;
    lockr = 32'h0000_0000;
    div = 3'h0;
    lk = 1'b0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 check(seen, expect_vec());
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      put(word_for(i[3:0], $random(seed)));
    end
    $display("test routing done");
    put(32'h0000_4004);
    put(32'h14a0_0046);
    put(32'h0000_0000);
    put(32'h0000_0004);
    put(32'h1460_0046);
    $display("test double buffer done");
    put(32'h0000_0044);
    put(word_for(SEL_OUT, $random(seed)));
    put(32'h0000_0004);
    $display("test power down done");
    put(32'h0e00_0007);
    put(word_for(SEL_OUT, $random(seed)));
    put(32'h0600_0007);
    put(word_for(SEL_OUT, $random(seed)));
    $display("test load sync done");
    put(32'h0400_0307);
    put(32'h7400_0846);
    @(posedge i_clk) in_win <= 1'b1;
    rises(3);
    #1 check(seen, expect_vec());
    rises(4);
    lk = 1'b1;
    #1 check(seen, expect_vec());
    put(32'h0000_0014);
    @(posedge i_clk) in_win <= 1'b0;
    put(32'h0000_0004);
    @(posedge i_clk) in_win <= 1'b1;
    rises(7);
    lk = 1'b1;
    #1 check(seen, expect_vec());
    @(posedge i_clk) in_win <= 1'b0;
    rises(2);
    lk = 1'b0;
    #1 check(seen, expect_vec());
    $display("test lock detect done");
    close_out();
  end

  initial begin
    repeat (40000) @(posedge i_clk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
